/* pscc_top.sv */
// supply-on control, led polarity and battery-backed control register behind apb
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_defines.svh"

module pscc_top #(
   parameter int tick_cycles = `PSCC_TICK_NS / `PSCC_CLK_NS
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`PSCC_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     standby_supply,
   input  wire logic                     sleep_s3_input,
   input  wire logic                     supply_on_polarity_strap,
   input  wire logic                     supply_power_good,
   input  wire logic [1:0]               led_lit,
   output logic                          supply_on_output,
   output logic [1:0]                    led_out
);

   // ******************************************************
   // pin synchronisers
   // ******************************************************
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic       stby_d;
   logic       sleep_d;

   // every pin here is asynchronous to pclk; only sync_b reads sync_a
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {supply_power_good, supply_on_polarity_strap,
                    sleep_s3_input, standby_supply};
         sync_b <= sync_a;
      end
   end

   wire logic stby_s   = sync_b[0];
   wire logic sleep_s  = sync_b[1];
   wire logic strap_s  = sync_b[2];
   wire logic pgood_s  = sync_b[3];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stby_d  <= 1'b0;
         sleep_d <= 1'b0;
      end else begin
         stby_d  <= stby_s;
         sleep_d <= sleep_s;
      end
   end

   // detectors reset low like an idle unpowered pin, so no false edge follows reset
   wire logic stby_rise  = stby_s & ~stby_d;
   wire logic stby_fall  = ~stby_s & stby_d;
   wire logic sleep_edge = sleep_s ^ sleep_d;

   // ******************************************************
   // apb slave
   // ******************************************************
   logic       led_pol;
   logic       last_on;
   logic       on_pol;
   logic [1:0] crowbar;
   logic       resume;
   logic       btn_mode;

   // lane 0 carries the whole byte-wide register; the other lanes are ignored
   wire logic hit      = (paddr == `PSCC_ADDR_CONTROL);
   wire logic access   = psel & penable & ~pready;
   wire logic complete = psel & penable & pready;
   wire logic wr_en    = complete & pwrite & hit & ~pslverr & pstrb[0];
   wire logic legacy   = (btn_mode == `PSCC_BTN_LEGACY);

   logic [7:0] read_value;

   always_comb begin
      read_value = 8'h0;
      read_value[`PSCC_BIT_LED_POL] = led_pol;
      // last state shown in legacy mode
      read_value[`PSCC_BIT_LAST_ON] = legacy & last_on;
      read_value[`PSCC_BIT_ON_POL]  = on_pol;
      read_value[`PSCC_BIT_CROW_HI:`PSCC_BIT_CROW_LO] = crowbar;
      read_value[`PSCC_BIT_RESUME]  = resume;
      read_value[`PSCC_BIT_PS_OFF]  = 1'b0;
      read_value[`PSCC_BIT_BTN_MODE] = btn_mode;
   end

   // one wait state: pready rises the cycle after the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   // unmapped offsets answer with an error and change nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~hit;
      end
   end

   // read data stands only in the answer cycle, zero otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (access && hit && !pwrite) begin
         prdata <= {24'h0, read_value};
      end else begin
         prdata <= 32'h0;
      end
   end

   // ******************************************************
   // battery-backed fields
   // ******************************************************
   // only the battery reset sets these, to code 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crowbar <= `PSCC_RST_CROWBAR;
      end else if (wr_en) begin
         crowbar <= pwdata[`PSCC_BIT_CROW_HI:`PSCC_BIT_CROW_LO];
      end
   end

   // resume select written by software, kept on the battery too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume <= `PSCC_RST_RESUME;
      end else if (wr_en) begin
         resume <= pwdata[`PSCC_BIT_RESUME];
      end
   end

   // standby power-up wins over a write in the same cycle
   // led polarity cleared at standby power-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_pol <= `PSCC_RST_LED_POL;
      end else if (stby_rise) begin
         led_pol <= `PSCC_RST_LED_POL;
      end else if (wr_en) begin
         led_pol <= pwdata[`PSCC_BIT_LED_POL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btn_mode <= `PSCC_RST_BTN_MODE;
      end else if (stby_rise) begin
         btn_mode <= `PSCC_RST_BTN_MODE;
      end else if (wr_en) begin
         btn_mode <= pwdata[`PSCC_BIT_BTN_MODE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_pol <= `PSCC_RST_ON_POL;
      end else if (stby_rise) begin
         on_pol <= strap_s;
      end
   end

   // ******************************************************
   // supply state
   // ******************************************************
   pscc_pkg::pscc_state_type state;
   pscc_pkg::pscc_state_type next_state;
   logic                     crowbar_trip;

   wire logic is_on = (state == pscc_pkg::PSCC_ON);

   // on state caught as standby disappears
   // taken from the internal state, so bit 6 does not depend on pin polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_on <= `PSCC_RST_LAST_ON;
      end else if (stby_fall) begin
         last_on <= is_on;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         pscc_pkg::PSCC_UNPOWERED: begin
            // restore or follow sleep at power return
            if (stby_rise) begin
               if (resume ? last_on : sleep_s) begin
                  next_state = pscc_pkg::PSCC_ON;
               end else begin
                  next_state = pscc_pkg::PSCC_OFF;
               end
            end
         end
         pscc_pkg::PSCC_OFF: begin
            if (stby_fall) begin
               next_state = pscc_pkg::PSCC_UNPOWERED;
            end else if (sleep_edge && sleep_s) begin
               // only a fresh rising edge switches on, so a supply cut by the
               // crowbar is not retried while the sleep input stays high
               // follow sleep input
               next_state = pscc_pkg::PSCC_ON;
            end
         end
         pscc_pkg::PSCC_ON: begin
            // standby loss outranks all; the crowbar outranks software
            if (stby_fall) begin
               next_state = pscc_pkg::PSCC_UNPOWERED;
            end else if (crowbar_trip) begin
               next_state = pscc_pkg::PSCC_OFF;
            end else if (wr_en && legacy && pwdata[`PSCC_BIT_PS_OFF]) begin
               next_state = pscc_pkg::PSCC_OFF;
            end else if (sleep_edge && !sleep_s) begin
               next_state = pscc_pkg::PSCC_OFF;
            end
         end
         default: begin
            next_state = pscc_pkg::PSCC_UNPOWERED;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pscc_pkg::PSCC_UNPOWERED;
      end else begin
         state <= next_state;
      end
   end

   // ******************************************************
   // crowbar timer
   // ******************************************************
   // supply must report good before the timeout or it is switched off
   // the count restarts whenever power-good returns or the supply goes off
   pscc_crowbar #(
      .tick_cycles (tick_cycles)
   ) u_crowbar (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (is_on & ~pgood_s),
      .code    (crowbar),
      .trip    (crowbar_trip)
   );

   // ******************************************************
   // output pins
   // ******************************************************
   // one helper turns a lit or on request into the pin level
   function automatic logic pscc_drive_level(input logic active, input logic active_low);
      pscc_drive_level = active ^ active_low;
   endfunction : pscc_drive_level

   // on state through polarity, 1 means active high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // polarity resets to active low, so the inactive level is high
         supply_on_output <= 1'b1;
      end else begin
         supply_on_output <= pscc_drive_level(is_on, ~on_pol);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_out <= 2'h0;
      end else begin
         led_out <= {pscc_drive_level(led_lit[1], led_pol),
                     pscc_drive_level(led_lit[0], led_pol)};
      end
   end

endmodule : pscc_top
`default_nettype wire

/* pscc_defines.svh */
// offsets, field positions, reset values and timing figures of the supply control block
`ifndef PSCC_DEFINES_SVH
`define PSCC_DEFINES_SVH

// ******************************************************
// register map
// ******************************************************
`define PSCC_IDX_CONTROL      8'h2D
`define PSCC_ADDR_CONTROL     {2'h0, `PSCC_IDX_CONTROL, 2'h0}
`define PSCC_ADDR_W           12

// ******************************************************
// control register fields
// ******************************************************
`define PSCC_BIT_LED_POL      7
`define PSCC_BIT_LAST_ON      6
`define PSCC_BIT_ON_POL       5
`define PSCC_BIT_CROW_HI      4
`define PSCC_BIT_CROW_LO      3
`define PSCC_BIT_RESUME       2
`define PSCC_BIT_PS_OFF       1
`define PSCC_BIT_BTN_MODE     0

// ******************************************************
// reset values
// ******************************************************
`define PSCC_RST_LED_POL      1'h0
`define PSCC_RST_LAST_ON      1'h0
`define PSCC_RST_ON_POL       1'h0
`define PSCC_RST_CROWBAR      2'h3
`define PSCC_RST_RESUME       1'h0
`define PSCC_RST_BTN_MODE     1'h0
`define PSCC_BTN_LEGACY       1'h0

// ******************************************************
// timing
// ******************************************************
`define PSCC_CLK_NS           5
`define PSCC_TICK_NS          1000000
`define PSCC_CROWBAR_MS_0     12'd600
`define PSCC_CROWBAR_MS_1     12'd1100
`define PSCC_CROWBAR_MS_2     12'd1600
`define PSCC_CROWBAR_MS_3     12'd2100

`endif

/* pscc_pkg.sv */
// types shared by the supply control block
`default_nettype none
package pscc_pkg;

   // ******************************************************
   // supply state, one-hot
   // ******************************************************
   typedef enum logic [2:0] {
      PSCC_UNPOWERED = 3'b001,
      PSCC_OFF       = 3'b010,
      PSCC_ON        = 3'b100
   } pscc_state_type;

   typedef logic [1:0] pscc_crowbar_code_type;

endpackage : pscc_pkg
`default_nettype wire

/* pscc_crowbar.sv */
// crowbar timer: millisecond divider and timeout counter
`timescale 1ns/1ps
`default_nettype none
`include "pscc_defines.svh"

module pscc_crowbar #(
   parameter int tick_cycles = `PSCC_TICK_NS / `PSCC_CLK_NS
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           run,
   input  wire pscc_pkg::pscc_crowbar_code_type code,
   output logic                                trip
);

   logic [31:0] prescale;
   logic        tick;
   logic [11:0] ms_count;

   // typical figures sit mid-range, so neighbouring settings stay apart
   function automatic logic [11:0] pscc_limit(input pscc_pkg::pscc_crowbar_code_type c);
      case (c)
         2'h0:    pscc_limit = `PSCC_CROWBAR_MS_0;
         2'h1:    pscc_limit = `PSCC_CROWBAR_MS_1;
         2'h2:    pscc_limit = `PSCC_CROWBAR_MS_2;
         default: pscc_limit = `PSCC_CROWBAR_MS_3;
      endcase
   endfunction : pscc_limit

   // ******************************************************
   // millisecond enable
   // ******************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 32'h0;
         tick     <= 1'b0;
      end else if (!run) begin
         prescale <= 32'h0;
         tick     <= 1'b0;
      end else if (prescale == 32'(tick_cycles - 1)) begin
         prescale <= 32'h0;
         tick     <= 1'b1;
      end else begin
         prescale <= prescale + 32'h1;
         tick     <= 1'b0;
      end
   end

   // ******************************************************
   // timeout count
   // ******************************************************
   // timeout per code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_count <= 12'h0;
         trip     <= 1'b0;
      end else if (!run) begin
         ms_count <= 12'h0;
         trip     <= 1'b0;
      end else if (tick && (ms_count == pscc_limit(code) - 12'h1)) begin
         ms_count <= 12'h0;
         trip     <= 1'b1;
      end else begin
         ms_count <= ms_count + {11'h0, tick};
         trip     <= 1'b0;
      end
   end

endmodule : pscc_crowbar
`default_nettype wire

/* pscc_checker.sv */
// bus and output relations of the supply control block
`timescale 1ns/1ps
`default_nettype none
`include "pscc_defines.svh"
module pscc_checker #(
   parameter int tick_cycles = 10
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`PSCC_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    standby_supply,
   input wire logic                    sleep_s3_input,
   input wire logic                    supply_on_polarity_strap,
   input wire logic                    supply_power_good,
   input wire logic [1:0]              led_lit,
   input wire logic                    supply_on_output,
   input wire logic [1:0]              led_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ******************************************************
   // bus answer
   // ******************************************************
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_cause; pready |-> $past(psel && penable); endproperty
   a_cause: assert property (p_cause) else $error("ready without access");
   property p_err; pready |-> pslverr == (paddr != `PSCC_ADDR_CONTROL); endproperty
   a_err: assert property (p_err) else $error("error flag wrong for address");
   property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   // ******************************************************
   // register fields and outputs
   // ******************************************************
   property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits not zero");
   property p_off_bit; pready && !pwrite |-> !prdata[1]; endproperty
   a_off_bit: assert property (p_off_bit) else $error("supply off bit read one");
   property p_hide; pready && !pwrite && !pslverr && prdata[0] |-> !prdata[6]; endproperty
   a_hide: assert property (p_hide) else $error("last state shown in acpi mode");
   property p_led; $past(presetn) |-> (led_out ^ $past(led_lit)) inside {2'b00, 2'b11}; endproperty
   a_led: assert property (p_led) else $error("leds differ in polarity");
endmodule : pscc_checker
bind pscc_top pscc_checker #(.tick_cycles(tick_cycles)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .standby_supply(standby_supply), .sleep_s3_input(sleep_s3_input),
   .supply_on_polarity_strap(supply_on_polarity_strap), .supply_power_good(supply_power_good),
   .led_lit(led_lit), .supply_on_output(supply_on_output), .led_out(led_out));
`default_nettype wire

/* pscc_supply_model.sv */
// behavioural power supply and chipset sleep output
`timescale 1ns/1ps
`default_nettype none
module pscc_supply_model (
   input  wire logic pclk,
   input  wire logic standby_supply,
   input  wire logic supply_on_output,
   input  wire logic polarity,
   input  wire logic run_req,
   input  wire logic fail_good,
   output logic      sleep_s3_input,
   output logic      supply_power_good
);
   int ramp;
   initial begin
      sleep_s3_input = 1'b0;
      supply_power_good = 1'b0;
      ramp = 0;
   end
   always @(posedge pclk) begin
      sleep_s3_input <= standby_supply & run_req;
   end
   // good only after a ramp; fail_good keeps it low so the crowbar trips
   always @(posedge pclk) begin
      if (supply_on_output == polarity && !fail_good) begin
         ramp <= ramp + 1;
      end else begin
         ramp <= 0;
      end
      supply_power_good <= (ramp >= 4);
   end
endmodule : pscc_supply_model
`default_nettype wire

/* pscc_top_tb.sv */
// self-checking bench for the supply control block
`timescale 1ns/1ps
`default_nettype none
`include "pscc_defines.svh"
module pscc_top_tb;
   localparam int          TICK = 10;
   localparam logic [11:0] ADR  = `PSCC_ADDR_CONTROL;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        standby_supply, strap, run_req, fail_good, sleep_s3_input;
   logic        supply_power_good, supply_on_output;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb;
   logic [1:0]  led_lit, led_out;
   int          mismatches, n_checks, n, lo, hi;

   pscc_top #(.tick_cycles(TICK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_supply(standby_supply),
      .sleep_s3_input(sleep_s3_input), .supply_on_polarity_strap(strap),
      .supply_power_good(supply_power_good), .led_lit(led_lit),
      .supply_on_output(supply_on_output), .led_out(led_out));
   pscc_supply_model u_sup (.pclk(pclk), .standby_supply(standby_supply),
      .supply_on_output(supply_on_output), .polarity(strap), .run_req(run_req),
      .fail_good(fail_good), .sleep_s3_input(sleep_s3_input),
      .supply_power_good(supply_power_good));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ******************************************************
   // tasks
   // ******************************************************
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] v);
      apb(1'b1, ADR, v, 4'h1);
   endtask : wr
   task rd(input string nm, input logic [7:0] v);
      apb(1'b0, ADR, 8'h00, 4'h1);
      chk(nm, {24'h0, v}, q);
      chk("read error flag", 32'h0, {31'h0, e});
   endtask : rd
   task pin(input string nm, input logic v);
      chk(nm, {31'h0, v}, {31'h0, supply_on_output});
   endtask : pin
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // crowbar runs take about 54000 cycles in all
   initial begin
      repeat (80000) @(posedge pclk);
      mismatches++;
      end_sim();
   end
   // ******************************************************
   // tests
   // ******************************************************
   initial begin
      {presetn, psel, penable, pwrite, standby_supply, run_req, fail_good} = 7'h00;
      {paddr, pwdata, pstrb, led_lit, strap} = 51'h1;
      mismatches = 0;
      n_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctl at reset", 8'h18);
      standby_supply <= 1'b1;
      repeat (6) @(posedge pclk);
      rd("ctl standby up", 8'h38);
      pin("pin off", 1'b0);
      $display("test power-up done");
      led_lit <= 2'b01;
      wr(8'hFF);
      rd("ctl all set", 8'hBD);
      chk("led out", 32'h2, {30'h0, led_out});
      wr(8'h00);
      rd("ctl cleared", 8'h20);
      apb(1'b1, ADR, 8'hFF, 4'h0);
      rd("ctl no lane", 8'h20);
      apb(1'b0, 12'h0B0, 8'h00, 4'h1);
      chk("bad address error", 32'h1, {31'h0, e});
      $display("test register done");
      run_req <= 1'b1;
      repeat (12) @(posedge pclk);
      pin("pin follows sleep", 1'b1);
      wr(8'h02);
      repeat (4) @(posedge pclk);
      pin("pin legacy off", 1'b0);
      run_req <= 1'b0;
      repeat (6) @(posedge pclk);
      run_req <= 1'b1;
      repeat (12) @(posedge pclk);
      wr(8'h01);
      wr(8'h03);
      repeat (4) @(posedge pclk);
      pin("pin acpi off ignored", 1'b1);
      $display("test supply off done");
      for (int c = 0; c < 4; c++) begin
         run_req <= 1'b0;
         fail_good <= 1'b1;
         wr({3'b000, 2'(c), 3'b000});
         repeat (8) @(posedge pclk);
         run_req <= 1'b1;
         repeat (10) @(posedge pclk);
         n = 0;
         while (supply_on_output === 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
         end
         lo = TICK * (400 + 500 * c);
         hi = TICK * ((c == 3) ? 2500 : 900 + 500 * c);
         chk("crowbar time", 32'h1, {31'h0, n >= lo && n <= hi});
      end
      fail_good <= 1'b0;
      run_req <= 1'b0;
      $display("test crowbar done");
      wr(8'h1C);
      run_req <= 1'b1;
      repeat (12) @(posedge pclk);
      pin("pin on before loss", 1'b1);
      standby_supply <= 1'b0;
      run_req <= 1'b0;
      repeat (8) @(posedge pclk);
      standby_supply <= 1'b1;
      repeat (8) @(posedge pclk);
      pin("pin restored", 1'b1);
      rd("ctl after loss", 8'h7C);
      wr(8'h1D);
      rd("ctl acpi hides", 8'h3D);
      $display("test restore done");
      end_sim();
   end
endmodule : pscc_top_tb
`default_nettype wire
